/* File: uart_pkg.sv */
/*
 Constants, field positions and state encodings for the serial data path.
 Assumes a 32-bit Avalon-MM slave with byte addresses on word boundaries.
*/
package uart_pkg;
  localparam logic [5:0] OFS_DATA        = 6'h00;
  localparam logic [5:0] OFS_INT_EN      = 6'h04;
  localparam logic [5:0] OFS_LINE_CTRL   = 6'h08;
  localparam logic [5:0] OFS_MODEM_CTRL  = 6'h0c;
  localparam logic [5:0] OFS_MODEM_STATE = 6'h10;
  localparam logic [5:0] OFS_SCRATCH     = 6'h14;
  localparam logic [5:0] OFS_DIV_LO      = 6'h18;
  localparam logic [5:0] OFS_DIV_HI      = 6'h1c;
  localparam logic [5:0] OFS_FIFO_CTRL   = 6'h20;
  localparam logic [5:0] OFS_LINE_STAT   = 6'h24;
  localparam int MC_DTR   = 0;
  localparam int MC_RTS   = 1;
  localparam int MC_USER1 = 2;
  localparam int MC_USER2 = 3;
  localparam int MC_LOOP  = 4;
  localparam int LC_STOP2 = 2;
  localparam int LC_PAREN = 3;
  localparam int LC_EVEN  = 4;
  localparam int IE_RX    = 0;
  localparam int IE_TX    = 1;
  localparam int FC_EN    = 0;
  localparam logic [7:0]  DIV_LO_RST = 8'h0c;
  localparam logic [7:0]  DIV_HI_RST = 8'h00;
  localparam logic [7:0]  LC_RST     = 8'h03;
  localparam logic [15:0] DIV_ONE    = 16'h0001;
  localparam logic [5:0]  BIT_END    = 6'h0f;
  localparam logic [5:0]  HALF_END   = 6'h07;
  localparam logic [5:0]  STOP1_END  = 6'h0f;
  localparam logic [5:0]  STOP15_END = 6'h17;
  localparam logic [5:0]  STOP2_END  = 6'h1f;
  localparam logic [4:0]  TRIG_0     = 5'h01;
  localparam logic [4:0]  TRIG_1     = 5'h04;
  localparam logic [4:0]  TRIG_2     = 5'h08;
  localparam logic [4:0]  TRIG_3     = 5'h0e;
  localparam logic [4:0]  FIFO_DEPTH = 5'h10;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA = 5'b00100,
    ST_PAR = 5'b01000,
    ST_STOP = 5'b10000
  } frame_state_t;
endpackage

/* File: uart_core.sv */
/*
 Baud generator, transmit and receive paths, scratch and modem state of a UART.
 Assumes a 32-bit Avalon-MM slave with waitrequest on sys_clk_i and
 asynchronous serial and modem pins that are synchronised here.
*/
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps

module uart_fifo
  import uart_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       push_i,
  input  wire logic [7:0] data_i,
  input  wire logic       pop_i,
  output logic      [7:0] data_o,
  output logic      [4:0] count_o
);
  logic [7:0] mem_q [16];
  logic [3:0] wr_q;
  logic [3:0] rd_q;
  assign data_o = mem_q[rd_q];
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q    <= 4'h0;
      rd_q    <= 4'h0;
      count_o <= 5'h00;
    end else begin
      if (push_i) wr_q <= wr_q + 4'h1;
      if (pop_i) rd_q <= rd_q + 4'h1;
      count_o <= count_o + {4'h0, push_i} - {4'h0, pop_i};
    end
  end
  always_ff @(posedge clk_i) begin
    if (push_i) mem_q[wr_q] <= data_i;
  end
endmodule // uart_fifo

module uart_core
  import uart_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [5:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  input  wire logic        serial_input_i,
  output logic             serial_output_o,
  output logic             baud_clock_output_o,
  input  wire logic        cts_n_i,
  input  wire logic        dsr_n_i,
  input  wire logic        ri_n_i,
  input  wire logic        dcd_n_i,
  output logic             dtr_n_o,
  output logic             rts_n_o,
  output logic             user_output_one_n_o,
  output logic             user_output_two_n_o,
  output logic             irq_o
);
  logic [7:0]   ie_q, lc_q, mc_q, sc_q, fc_q, div_lo_q, div_hi_q, ms_q, dms_q;
  logic [15:0]  cnt_q;
  logic [4:0]   s1_q, s2_q;
  logic         pe_q, fe_q, oe_q;
  logic [4:0]   tx_cnt, rx_cnt;
  logic [7:0]   tx_head, rx_head;
  frame_state_t tx_st_q, rx_st_q;
  logic [7:0]   tx_sh_q, rx_sh_q, sk0_q, sk1_q;
  logic [5:0]   tx_ph_q, rx_ph_q;
  logic [2:0]   tx_ix_q, rx_ix_q;
  logic         tx_bit_q, tx_par_q, rx_par_q;
  logic [1:0]   skn_q;

  // Bus decode: a request is taken once; waitrequest drops the next cycle.
  wire       req     = read_i | write_i;
  wire       be0     = byteenable_i[0];
  wire       fifo_en = fc_q[FC_EN];
  wire       loop    = mc_q[MC_LOOP];
  wire       tx_room = fifo_en ? (tx_cnt != FIFO_DEPTH) : (tx_cnt == 5'h00);
  wire       go      = ~(write_i & be0 & (address_i == OFS_DATA)) | tx_room;
  wire       take    = waitrequest_o & req & go;
  wire       wr      = take & write_i & be0;
  wire       rd      = take & read_i;
  wire [7:0] wd      = writedata_i[7:0];
  wire       sel_lo  = address_i == OFS_DIV_LO;
  wire       sel_hi  = address_i == OFS_DIV_HI;
  wire       tx_push = wr & (address_i == OFS_DATA);
  wire       rx_pop  = rd & (address_i == OFS_DATA) & (rx_cnt != 5'h00);
  wire       ms_rd   = rd & (address_i == OFS_MODEM_STATE);
  wire       ls_rd   = rd & (address_i == OFS_LINE_STAT);
  wire [15:0] div_new = {(wr & sel_hi) ? wd : div_hi_q, (wr & sel_lo) ? wd : div_lo_q};
  wire       div_wr  = wr & (sel_lo | sel_hi);
  wire       tick_d  = ~div_wr & (cnt_q <= DIV_ONE);
  wire       tick    = baud_clock_output_o;

  wire [2:0] last_ix  = 3'h4 + {1'b0, lc_q[1:0]};
  wire [5:0] stop_end = ~lc_q[LC_STOP2] ? STOP1_END
                      : (lc_q[1:0] == 2'b00) ? STOP15_END : STOP2_END;
  wire       par_en   = lc_q[LC_PAREN];
  wire [5:0] tx_endv  = (tx_st_q == ST_STOP) ? stop_end : BIT_END;
  wire       tx_end   = tick & (tx_ph_q == tx_endv);
  wire       tx_idle  = tx_st_q == ST_IDLE;
  wire       tx_pop   = tx_idle & (tx_cnt != 5'h00);

  // loopback feeds the receiver from the transmitter
  wire       rx_in    = loop ? tx_bit_q : s2_q[4];
  wire [5:0] rx_endv  = (rx_st_q == ST_START) ? HALF_END : BIT_END;
  wire       rx_end   = tick & (rx_ph_q == rx_endv);
  wire       rx_push  = (rx_st_q == ST_STOP) & rx_end;
  wire [7:0] rx_byte  = rx_sh_q >> (3'h7 - last_ix);
  wire       sk_in    = rx_push & (skn_q != 2'h2);
  wire       rx_room  = fifo_en ? (rx_cnt != FIFO_DEPTH) : (rx_cnt == 5'h00);
  wire       sk_out   = (skn_q != 2'h0) & rx_room;
  wire [1:0] sk_slot  = skn_q - {1'b0, sk_out};

  wire [3:0] ms_now = loop ? {mc_q[MC_USER2], mc_q[MC_USER1], mc_q[MC_DTR], mc_q[MC_RTS]}
                           : ~s2_q[3:0];
  wire [3:0] ms_chg = {ms_now[3] ^ ms_q[7], ms_q[6] & ~ms_now[2],
                       ms_now[1] ^ ms_q[5], ms_now[0] ^ ms_q[4]};
  wire [4:0] trig   = (fc_q[7:6] == 2'b00) ? TRIG_0 : (fc_q[7:6] == 2'b01) ? TRIG_1
                    : (fc_q[7:6] == 2'b10) ? TRIG_2 : TRIG_3;
  wire       rx_hit = fifo_en ? (rx_cnt >= trig) : (rx_cnt != 5'h00);
  wire       holding_empty_flag = tx_cnt == 5'h00;
  wire [7:0] ls_val = {1'b0, holding_empty_flag & tx_idle, holding_empty_flag, 1'b0,
                       fe_q, pe_q, oe_q, rx_cnt != 5'h00};
  wire [7:0] rd_val = (address_i == OFS_DATA)        ? rx_head
                    : (address_i == OFS_INT_EN)      ? ie_q
                    : (address_i == OFS_LINE_CTRL)   ? lc_q
                    : (address_i == OFS_MODEM_CTRL)  ? mc_q
                    : (address_i == OFS_MODEM_STATE) ? {ms_q[7:4], dms_q[3:0]}
                    : (address_i == OFS_SCRATCH)     ? sc_q
                    : sel_lo ? div_lo_q : sel_hi ? div_hi_q
                    : (address_i == OFS_FIFO_CTRL)   ? fc_q
                    : (address_i == OFS_LINE_STAT)   ? ls_val : 8'h00;

  uart_fifo u_tx_fifo (
    .clk_i   (sys_clk_i),
    .rst_i   (rst_i),
    .push_i  (tx_push),
    .data_i  (wd),
    .pop_i   (tx_pop),
    .data_o  (tx_head),
    .count_o (tx_cnt)
  );

  uart_fifo u_rx_fifo (
    .clk_i   (sys_clk_i),
    .rst_i   (rst_i),
    .push_i  (sk_out),
    .data_i  (sk0_q),
    .pop_i   (rx_pop),
    .data_o  (rx_head),
    .count_o (rx_cnt)
  );

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      waitrequest_o <= 1'b1;
      readdata_o    <= 32'h0;
      ie_q          <= 8'h00;
      lc_q          <= LC_RST;
      mc_q          <= 8'h00;
      sc_q          <= 8'h00;
      fc_q          <= 8'h00;
      div_lo_q      <= DIV_LO_RST;
      div_hi_q      <= DIV_HI_RST;
    end else begin
      waitrequest_o <= ~take;
      if (rd) readdata_o <= {24'h0, rd_val};
      if (wr & (address_i == OFS_INT_EN)) ie_q <= {6'h00, wd[1:0]};
      if (wr & (address_i == OFS_LINE_CTRL)) lc_q <= wd;
      if (wr & (address_i == OFS_MODEM_CTRL)) mc_q <= {3'h0, wd[4:0]};
      if (wr & (address_i == OFS_SCRATCH)) sc_q <= wd;
      if (wr & (address_i == OFS_FIFO_CTRL)) fc_q <= {wd[7:6], 5'h00, wd[0]};
      if (wr & sel_lo) div_lo_q <= wd;
      if (wr & sel_hi) div_hi_q <= wd;
    end
  end

  // Outputs are registered; loopback drives the modem pins inactive high.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q               <= {DIV_HI_RST, DIV_LO_RST};
      baud_clock_output_o <= 1'b0;
      serial_output_o     <= 1'b1;
      dtr_n_o             <= 1'b1;
      rts_n_o             <= 1'b1;
      user_output_one_n_o <= 1'b1;
      user_output_two_n_o <= 1'b1;
      irq_o               <= 1'b0;
    end else begin
      cnt_q               <= (div_wr | tick_d) ? div_new : cnt_q - 16'h0001;
      baud_clock_output_o <= tick_d;
      serial_output_o     <= loop | tx_bit_q;
      dtr_n_o             <= loop | ~mc_q[MC_DTR];
      rts_n_o             <= loop | ~mc_q[MC_RTS];
      user_output_one_n_o <= loop | ~mc_q[MC_USER1];
      user_output_two_n_o <= loop | ~mc_q[MC_USER2];
      irq_o               <= (ie_q[IE_RX] & rx_hit) | (ie_q[IE_TX] & holding_empty_flag);
    end
  end

  // Pins pass two flops; sticky flags let a new event win over a read clear.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q  <= 5'h1f;
      s2_q  <= 5'h1f;
      ms_q  <= 8'h00;
      dms_q <= 8'h00;
      pe_q  <= 1'b0;
      fe_q  <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      s1_q  <= {serial_input_i, dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
      s2_q  <= s1_q;
      ms_q  <= {ms_now, 4'h0};
      dms_q <= {4'h0, (ms_rd ? 4'h0 : dms_q[3:0]) | ms_chg};
      pe_q  <= (pe_q & ~ls_rd) | ((rx_st_q == ST_PAR) & rx_end & (rx_in ^ rx_par_q));
      fe_q  <= (fe_q & ~ls_rd) | (rx_push & ~rx_in);
      oe_q  <= (oe_q & ~ls_rd) | (rx_push & ~sk_in);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_q  <= ST_IDLE;
      tx_sh_q  <= 8'h00;
      tx_ph_q  <= 6'h00;
      tx_ix_q  <= 3'h0;
      tx_bit_q <= 1'b1;
      tx_par_q <= 1'b0;
    end else begin
      tx_ph_q <= (tx_idle | tx_end) ? 6'h00 : tx_ph_q + {5'h00, tick};
      case (tx_st_q)
        ST_IDLE: if (tx_pop) begin
          tx_sh_q  <= tx_head;
          tx_bit_q <= 1'b0;
          tx_par_q <= ~lc_q[LC_EVEN];
          tx_ix_q  <= 3'h0;
          tx_st_q  <= ST_START;
        end
        ST_START: if (tx_end) begin
          tx_bit_q <= tx_sh_q[0];
          tx_par_q <= tx_par_q ^ tx_sh_q[0];
          tx_st_q  <= ST_DATA;
        end
        ST_DATA: if (tx_end) begin
          if (tx_ix_q == last_ix) begin
            tx_bit_q <= par_en ? tx_par_q : 1'b1;
            tx_st_q  <= par_en ? ST_PAR : ST_STOP;
          end else begin
            tx_sh_q  <= tx_sh_q >> 1;
            tx_bit_q <= tx_sh_q[1];
            tx_par_q <= tx_par_q ^ tx_sh_q[1];
            tx_ix_q  <= tx_ix_q + 3'h1;
          end
        end
        ST_PAR: if (tx_end) begin
          tx_bit_q <= 1'b1;
          tx_st_q  <= ST_STOP;
        end
        ST_STOP: if (tx_end) tx_st_q <= ST_IDLE;
        default: tx_st_q <= ST_IDLE;
      endcase
    end
  end

  // The start bit is checked again at mid-bit so a glitch is not a character.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_st_q  <= ST_IDLE;
      rx_sh_q  <= 8'h00;
      rx_ph_q  <= 6'h00;
      rx_ix_q  <= 3'h0;
      rx_par_q <= 1'b0;
    end else begin
      rx_ph_q <= ((rx_st_q == ST_IDLE) | rx_end) ? 6'h00 : rx_ph_q + {5'h00, tick};
      case (rx_st_q)
        ST_IDLE: if (~rx_in) rx_st_q <= ST_START;
        ST_START: if (rx_end) begin
          rx_st_q  <= rx_in ? ST_IDLE : ST_DATA;
          rx_ix_q  <= 3'h0;
          rx_par_q <= ~lc_q[LC_EVEN];
        end
        ST_DATA: if (rx_end) begin
          rx_sh_q  <= {rx_in, rx_sh_q[7:1]};
          rx_par_q <= rx_par_q ^ rx_in;
          rx_ix_q  <= rx_ix_q + 3'h1;
          if (rx_ix_q == last_ix) rx_st_q <= par_en ? ST_PAR : ST_STOP;
        end
        ST_PAR: if (rx_end) rx_st_q <= ST_STOP;
        ST_STOP: if (rx_end) rx_st_q <= ST_IDLE;
        default: rx_st_q <= ST_IDLE;
      endcase
    end
  end

  // Two-entry buffer: a full receive FIFO stalls it; a word arriving with both entries held is lost and sets overrun.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      skn_q <= 2'h0;
      sk0_q <= 8'h00;
      sk1_q <= 8'h00;
    end else begin
      skn_q <= skn_q + {1'b0, sk_in} - {1'b0, sk_out};
      if (sk_out) sk0_q <= sk1_q;
      if (sk_in & (sk_slot == 2'h0)) sk0_q <= rx_byte;
      if (sk_in & (sk_slot == 2'h1)) sk1_q <= rx_byte;
    end
  end
endmodule // uart_core

/* File: uart_core_asserts.sv */
/* Checker for the bus, baud and modem pins of uart_core.
   Bound from the testbench top; sees only uart_core ports. */
`timescale 1ns/100ps
module uart_core_asserts
  import uart_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [5:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0]  byteenable_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic        serial_output_o,
  input wire logic        baud_clock_output_o,
  input wire logic        ri_n_i,
  input wire logic        dcd_n_i,
  input wire logic        dtr_n_o,
  input wire logic        rts_n_o,
  input wire logic        user_output_one_n_o,
  input wire logic        user_output_two_n_o
);
  logic [7:0]  mcr_q, scr_q;
  logic [15:0] div_q;
  logic [16:0] gap_q, div_eff;
  logic [3:0]  stab_q;
  logic        ok_q, tk_wr, tk_rd, div_wr;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  assign tk_wr = write_i && waitrequest_o && byteenable_i[0];
  assign tk_rd = read_i && waitrequest_o;
  assign div_wr = tk_wr && (address_i == OFS_DIV_LO || address_i == OFS_DIV_HI);
  assign div_eff = (div_q == 16'h0000) ? 17'h00001 : {1'b0, div_q};
  // Shadows follow the taking edge, the same edge the registers update on.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mcr_q <= 8'h00;
      scr_q <= 8'h00;
      div_q <= {DIV_HI_RST, DIV_LO_RST};
    end else if (tk_wr) begin
      if (address_i == OFS_MODEM_CTRL) mcr_q <= writedata_i[7:0];
      if (address_i == OFS_SCRATCH) scr_q <= writedata_i[7:0];
      if (address_i == OFS_DIV_LO) div_q[7:0] <= writedata_i[7:0];
      if (address_i == OFS_DIV_HI) div_q[15:8] <= writedata_i[7:0];
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q <= 17'h0;
      ok_q <= 1'b0;
      stab_q <= 4'h0;
    end else begin
      gap_q <= div_wr ? 17'h0 : (baud_clock_output_o ? 17'h1 : gap_q + 17'h1);
      ok_q <= !div_wr && (ok_q || baud_clock_output_o);
      stab_q <= ($changed(ri_n_i) || $changed(dcd_n_i) || (tk_wr && address_i ==
        OFS_MODEM_CTRL)) ? 4'h0 : ((stab_q == 4'hf) ? stab_q : stab_q + 4'h1);
    end
  end
  a_wait_pulse: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property (waitrequest_o && (read_i || (write_i &&
    address_i != OFS_DATA)) |=> !waitrequest_o) else $error("request not answered");
  a_rd_unmap: assert property (tk_rd && address_i >= 6'h28 |=> readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_scratch_back: assert property (
    tk_rd && address_i == OFS_SCRATCH |=> readdata_o[7:0] == scr_q)
    else $error("scratch readback wrong");
  a_line_state: assert property (
    tk_rd && address_i == OFS_MODEM_STATE && stab_q > 4'h7 |=> readdata_o[7:6] ==
    (mcr_q[MC_LOOP] ? mcr_q[MC_USER2:MC_USER1] : ~{$past(dcd_n_i), $past(ri_n_i)}))
    else $error("modem state bits 7:6 wrong");
  a_loop_pins: assert property (
    mcr_q[MC_LOOP] && $past(mcr_q[MC_LOOP]) |-> serial_output_o && dtr_n_o &&
    rts_n_o && user_output_one_n_o && user_output_two_n_o)
    else $error("pins not high in loopback");
  a_baud_gap: assert property (
    baud_clock_output_o && ok_q |-> gap_q == div_eff) else $error("baud period wrong");
  a_baud_late: assert property (gap_q <= div_eff + 17'h3)
    else $error("baud tick late after reload");
  c_baud: cover property (baud_clock_output_o && ok_q);
  c_loop_rd: cover property (tk_rd && address_i == OFS_MODEM_STATE && mcr_q[MC_LOOP]);
  c_tx_stall: cover property (write_i && address_i == OFS_DATA && waitrequest_o [*3]);
endmodule // uart_core_asserts

/* File: uart_line_partner.sv */
/* Serial peer: sends 8N1 frames on request and captures frames from the device.
   Assumes one bit lasts BIT_CYC clock cycles. */
`timescale 1ns/100ps
module uart_line_partner #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  logic [7:0] rx_q[$];
  logic [7:0] rb;
  initial line_o = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask
  always begin
    @(negedge line_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      rb[i] = line_i;
    end
    rx_q.push_back(rb);
    repeat (BIT_CYC) @(posedge clk_i);
  end
endmodule // uart_line_partner

/* File: uart_core_tb_top.sv */
/* Self-checking bench for uart_core with a serial peer and a bound checker.
   Assumes the register map and bus timing of uart_pkg and the hand-over. */
`timescale 1ns/100ps
module uart_core_tb_top
  import uart_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rd, wr, wreq, serial_input, serial_output, baud;
  logic        ri_n, dcd_n, cts_n, dsr_n, irq;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0]  be;
  logic [7:0]  d;
  logic [7:0]  b[4];
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          seed = 32'h4e147105;
  int          n;

  always #10 clk = ~clk;

  uart_core dut (.sys_clk_i(clk), .rst_i(rst), .address_i(addr), .read_i(rd), .write_i(wr),
    .writedata_i(wdata), .byteenable_i(be), .readdata_o(rdata), .waitrequest_o(wreq),
    .serial_input_i(serial_input), .serial_output_o(serial_output), .baud_clock_output_o(baud),
    .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ri_n_i(ri_n), .dcd_n_i(dcd_n), .dtr_n_o(),
    .rts_n_o(), .user_output_one_n_o(), .user_output_two_n_o(), .irq_o(irq));
  uart_line_partner #(.BIT_CYC(16)) pl (.clk_i(clk), .line_i(serial_output), .line_o(serial_input));

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then releases it.
  task automatic xfer(input logic [5:0] a, input logic w, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= {24'h0, v};
    be <= {3'($random(seed)), 1'b1};
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 3000);
    if (k >= 3000) chk("bus answer", 32'h0, 32'h1);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wait_rx();
    for (int k = 0; k < 300; k++) begin
      xfer(OFS_LINE_STAT, 1'b0, 8'h00);
      if (q[0] === 1'b1) break;
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    {rd, wr, addr, wdata, be} = '0;
    {ri_n, dcd_n, cts_n, dsr_n} = 4'hf;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    xfer(OFS_DIV_LO, 1'b0, 8'h00);
    chk("div_lo reset", {24'h0, DIV_LO_RST}, q);
    xfer(OFS_DIV_HI, 1'b0, 8'h00);
    chk("div_hi reset", {24'h0, DIV_HI_RST}, q);
    xfer(6'h3c, 1'b0, 8'h00);
    chk("unmapped", 32'h0, q);
    // both latches set before serial use
    xfer(OFS_DIV_LO, 1'b1, 8'h03);
    xfer(OFS_DIV_HI, 1'b1, 8'h00);
    repeat (12) @(posedge clk);
    xfer(OFS_DIV_LO, 1'b1, 8'h01);
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 8'hff : 8'($random(seed));
      xfer(OFS_SCRATCH, 1'b1, d);
      xfer(OFS_SCRATCH, 1'b0, 8'h00);
      chk("scratch", d, q);
    end
    xfer(OFS_DIV_LO, 1'b0, 8'h00);
    chk("div_lo", 32'h1, q);
    n = 0;
    repeat (32) begin
      @(posedge clk);
      if (baud === 1'b1) n++;
    end
    chk("baud ticks", 32, n);
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 8'h00 : 8'($random(seed));
      {ri_n, dcd_n, cts_n, dsr_n} <= d[3:0];
      repeat (8) @(posedge clk);
      xfer(OFS_MODEM_STATE, 1'b0, 8'h00);
      chk("line state", {30'h0, ~d[2], ~d[3]}, q[7:6]);
    end
    for (int i = 0; i < 4; i++) begin
      xfer(OFS_MODEM_CTRL, 1'b1, 8'h10 | 8'(i << 2));
      repeat (8) @(posedge clk);
      xfer(OFS_MODEM_STATE, 1'b0, 8'h00);
      chk("loop state", i, q[7:6]);
    end
    d = 8'($random(seed));
    xfer(OFS_DATA, 1'b1, d);
    wait_rx();
    xfer(OFS_INT_EN, 1'b1, 8'h01);
    @(posedge clk);
    chk("irq rx data", 32'h1, irq);
    xfer(OFS_DATA, 1'b0, 8'h00);
    chk("loop byte", d, q);
    @(posedge clk);
    chk("irq rx cleared", 32'h0, irq);
    xfer(OFS_INT_EN, 1'b1, 8'h02);
    @(posedge clk);
    chk("irq tx empty", 32'h1, irq);
    xfer(OFS_INT_EN, 1'b1, 8'h00);
    xfer(OFS_MODEM_CTRL, 1'b1, 8'h00);
    for (int i = 0; i < 3; i++) begin
      b[i] = (i == 0) ? 8'h80 : 8'($random(seed));
      xfer(OFS_DATA, 1'b1, b[i]);
    end
    repeat (600) @(posedge clk);
    chk("tx count", 32'h3, pl.rx_q.size());
    for (int i = 0; i < 3; i++) chk("tx byte", b[i], pl.rx_q[i]);
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($random(seed));
      pl.send(b[i]);
    end
    repeat (20) @(posedge clk);
    xfer(OFS_LINE_STAT, 1'b0, 8'h00);
    chk("overrun", 32'h1, q[1]);
    for (int i = 0; i < 3; i++) begin
      xfer(OFS_DATA, 1'b0, 8'h00);
      chk("rx byte", b[i], q);
    end
    repeat (4) @(posedge clk);
    xfer(OFS_LINE_STAT, 1'b0, 8'h00);
    chk("rx empty", 32'h0, q[0]);
    summarize();
  end
endmodule // uart_core_tb_top

bind uart_core uart_core_asserts u_chk (.sys_clk_i, .rst_i, .address_i, .read_i, .write_i,
  .writedata_i, .byteenable_i, .readdata_o, .waitrequest_o, .serial_output_o,
  .baud_clock_output_o, .ri_n_i, .dcd_n_i, .dtr_n_o, .rts_n_o, .user_output_one_n_o,
  .user_output_two_n_o);
